// >>> verilog/mcel_pkg.sv
// Constants and types for the error logging block
package mcel_pkg;
	// APB register byte addresses
	localparam logic [7:0] ADDR_BANK0_STATUS = 8'h00;
	localparam logic [7:0] ADDR_BANK1_STATUS = 8'h04;
	localparam logic [7:0] ADDR_BANK1_ADDR = 8'h08;
	localparam logic [7:0] ADDR_BANK2_CTL = 8'h0C;
	localparam logic [7:0] ADDR_BANK2_STATUS = 8'h10;
	localparam logic [7:0] ADDR_QUEUE = 8'h14;
	// Status field positions
	localparam int BIT_VALID = 0;
	localparam int BIT_UNCORRECTABLE = 1;
	localparam int BIT_CTX_CORRUPT = 2;
	localparam int BIT_CORR = 3;
	localparam int BIT_HARDFAIL = 4;
	localparam int BIT_MULTITAG = 5;
	localparam int BIT_PREFETCH = 6;
	localparam int BIT_ADDRV = 7;
	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_BANK2_CTL = 8'hFF;
	localparam logic [31:0] RST_ADDR = 32'h0000_0000;
	// Bus queue depth
	localparam int QDEPTH = 4;
	localparam int QIDW = 2;
	// Error event kinds on the input port
	typedef enum logic [2:0] {
		EV_NONE = 3'b000,
		EV_PF_TAG_ERR = 3'b001,
		EV_DEMAND_ERR = 3'b010,
		EV_L1_PARITY = 3'b011,
		EV_FETCH_SPLIT = 3'b100,
		EV_OWN_MULTITAG = 3'b101,
		EV_BANK2_ERR = 3'b110,
		EV_HARDFAIL = 3'b111
	} mcel_event_t;
endpackage : mcel_pkg

// >>> verilog/mcel_top.sv
// Error reporting banks, bus queue cleanup and APB register access
`timescale 1ns/1ps
module mcel_top
	import mcel_pkg::*;
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Error event port from the caches and bus unit
	input wire logic I_EV_VALID,
	input wire mcel_pkg::mcel_event_t I_EV_KIND,
	input wire logic [31:0] I_EV_ADDR,
	input wire logic [mcel_pkg::QIDW-1:0] I_EV_QID,
	input wire logic I_EV_DEFERRED,
	input wire logic I_HALF0_BAD,
	input wire logic I_HALF1_BAD,
	// Bus queue allocation
	input wire logic I_Q_ALLOC,
	input wire logic [mcel_pkg::QIDW-1:0] I_Q_ALLOC_ID,
	// Results
	output logic O_MCHK,
	output logic O_FETCH_STALL,
	output logic [mcel_pkg::QDEPTH-1:0] O_Q_BUSY
);
	import mcel_pkg::*;

	// Bank state
	logic [7:0] b0_q, b0_d; // Bus/L2 bank status
	logic [7:0] b1_q, b1_d; // L1 bank status
	logic [31:0] a1_q, a1_d; // L1 error address
	logic [7:0] ctl2_q, ctl2_d; // Bank2 report enables
	logic [7:0] b2_q, b2_d; // Bank2 status
	logic [31:0] pf_addr_q, pf_addr_d; // Address of logged prefetch tag error
	logic [QDEPTH-1:0] qb_q, qb_d; // Bus queue occupancy
	logic mchk_q, mchk_d; // Machine check exception pulse
	logic [31:0] rdata_q, rdata_d; // Registered read data

	wire logic acc = I_PSEL & I_PENABLE; // Access phase, answered at once
	wire logic wr = acc & I_PWRITE;
	wire logic ev = I_EV_VALID;
	logic mapped;

	// Address decode
	always_comb begin
		unique case (I_PADDR)
			ADDR_BANK0_STATUS, ADDR_BANK1_STATUS, ADDR_BANK1_ADDR,
			ADDR_BANK2_CTL, ADDR_BANK2_STATUS, ADDR_QUEUE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Next state of banks, queue and exception
	always_comb begin
		b0_d = b0_q;
		b1_d = b1_q;
		a1_d = a1_q;
		ctl2_d = ctl2_q;
		b2_d = b2_q;
		pf_addr_d = pf_addr_q;
		qb_d = qb_q;
		mchk_d = 1'b0;
		rdata_d = rdata_q;
		// Software writes first so a same-cycle event wins over the clear
		if (wr) begin
			unique case (I_PADDR)
				ADDR_BANK0_STATUS: b0_d = I_PWDATA[7:0];
				ADDR_BANK1_STATUS: b1_d = I_PWDATA[7:0];
				ADDR_BANK1_ADDR: a1_d = I_PWDATA;
				ADDR_BANK2_CTL: ctl2_d = I_PWDATA[7:0];
				ADDR_BANK2_STATUS: b2_d = I_PWDATA[7:0];
				default: ;
			endcase
		end
		// Queue allocation from the bus unit
		if (I_Q_ALLOC) begin
			qb_d[I_Q_ALLOC_ID] = 1'b1;
		end
		if (ev) begin
			unique case (I_EV_KIND)
				EV_HARDFAIL: begin
					b0_d[BIT_VALID] = 1'b1;
					b0_d[BIT_HARDFAIL] = 1'b1;
					// Deferred entry freed so later requests proceed
					if (I_EV_DEFERRED) begin
						qb_d[I_EV_QID] = 1'b0;
					end
				end
				EV_PF_TAG_ERR: begin
					// Data never consumed, so only log it
					b0_d[BIT_VALID] = 1'b1;
					b0_d[BIT_UNCORRECTABLE] = 1'b1;
					b0_d[BIT_CTX_CORRUPT] = 1'b1;
					b0_d[BIT_PREFETCH] = 1'b1;
					pf_addr_d = I_EV_ADDR;
				end
				EV_DEMAND_ERR: begin
					b0_d[BIT_VALID] = 1'b1;
					b0_d[BIT_UNCORRECTABLE] = 1'b1;
					b0_d[BIT_CTX_CORRUPT] = 1'b1;
					mchk_d = 1'b1;
				end
				EV_L1_PARITY: begin
					// Only the first fault's address is kept; later ops cannot replace it
					if (!b1_q[BIT_VALID]) begin
						a1_d = I_EV_ADDR;
						b1_d[BIT_ADDRV] = 1'b1;
					end
					b1_d[BIT_VALID] = 1'b1;
					b1_d[BIT_UNCORRECTABLE] = 1'b1;
				end
				EV_FETCH_SPLIT: begin
					b0_d[BIT_VALID] = 1'b1;
					if (I_HALF0_BAD | I_HALF1_BAD) begin
						b0_d[BIT_UNCORRECTABLE] = 1'b1;
						mchk_d = 1'b1;
					end else begin
						b0_d[BIT_CORR] = 1'b1;
					end
				end
				EV_OWN_MULTITAG: begin
					b0_d[BIT_VALID] = 1'b1;
					b0_d[BIT_MULTITAG] = 1'b1;
				end
				EV_BANK2_ERR: begin
					b2_d[BIT_VALID] = 1'b1;
					b2_d[BIT_UNCORRECTABLE] = 1'b1;
					mchk_d = |ctl2_q;
				end
				default: ;
			endcase
			// Demand access to the poisoned prefetch location
			if (I_EV_KIND != EV_PF_TAG_ERR && b0_q[BIT_PREFETCH] && I_EV_ADDR == pf_addr_q
				&& I_EV_KIND != EV_BANK2_ERR && I_EV_KIND != EV_NONE) begin
				mchk_d = 1'b1;
			end
		end
		// Read mux
		if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
			unique case (I_PADDR)
				ADDR_BANK0_STATUS: rdata_d = {24'h000000, b0_q};
				ADDR_BANK1_STATUS: rdata_d = {24'h000000, b1_q};
				ADDR_BANK1_ADDR: rdata_d = a1_q;
				ADDR_BANK2_CTL: rdata_d = {24'h000000, ctl2_q};
				ADDR_BANK2_STATUS: rdata_d = {24'h000000, b2_q};
				ADDR_QUEUE: rdata_d = {28'h0000000, qb_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			b0_q <= RST_STATUS;
			b1_q <= RST_STATUS;
			a1_q <= RST_ADDR;
			ctl2_q <= RST_BANK2_CTL;
			b2_q <= RST_STATUS;
			pf_addr_q <= RST_ADDR;
			qb_q <= 4'h0;
			mchk_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			b0_q <= b0_d;
			b1_q <= b1_d;
			a1_q <= a1_d;
			ctl2_q <= ctl2_d;
			b2_q <= b2_d;
			pf_addr_q <= pf_addr_d;
			qb_q <= qb_d;
			mchk_q <= mchk_d;
			rdata_q <= rdata_d;
		end
	end

	// Outputs; fetch never stalls since correction is skipped when a half is bad
	assign O_PRDATA = rdata_q;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = acc & ~mapped;
	assign O_MCHK = mchk_q;
	assign O_FETCH_STALL = 1'b0;
	assign O_Q_BUSY = qb_q;

	// Checks
	chk_hardfail_dequeue: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		ev && I_EV_KIND == EV_HARDFAIL && I_EV_DEFERRED && !(I_Q_ALLOC && I_Q_ALLOC_ID == I_EV_QID)
		|=> !O_Q_BUSY[$past(I_EV_QID)]) else $error("hard-failed entry stayed queued");
	chk_prefetch_quiet: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		ev && I_EV_KIND == EV_PF_TAG_ERR && !(b0_q[BIT_PREFETCH] && I_EV_ADDR == pf_addr_q)
		|=> !O_MCHK && b0_q[BIT_UNCORRECTABLE] && b0_q[BIT_CTX_CORRUPT]) else $error("prefetch tag error handling wrong");
	chk_demand_poison: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		ev && I_EV_KIND == EV_OWN_MULTITAG && b0_q[BIT_PREFETCH] && I_EV_ADDR == pf_addr_q
		|=> O_MCHK) else $error("demand hit on poisoned line missed");
	chk_demand_error: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		ev && I_EV_KIND == EV_DEMAND_ERR |=> O_MCHK && b0_q[BIT_UNCORRECTABLE]) else $error("demand error not raised");
	chk_bank2_disabled: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		ev && I_EV_KIND == EV_BANK2_ERR && ctl2_q == 8'h00 && !b0_q[BIT_PREFETCH]
		|=> !O_MCHK && b2_q[BIT_UNCORRECTABLE]) else $error("disabled bank2 misbehaved");
	chk_l1_addr_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		b1_q[BIT_VALID] && !wr |=> a1_q == $past(a1_q)) else $error("L1 address overwritten");
	chk_no_stall: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		ev && I_EV_KIND == EV_FETCH_SPLIT && (I_HALF0_BAD ^ I_HALF1_BAD)
		|=> !O_FETCH_STALL && b0_q[BIT_UNCORRECTABLE]) else $error("split fetch stalled");
	chk_multitag_log: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		ev && I_EV_KIND == EV_OWN_MULTITAG |=> b0_q[BIT_MULTITAG]) else $error("multi-tag not logged");
	chk_status_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		!ev && !wr |=> $stable(b0_q) && $stable(b2_q)) else $error("status changed without cause");
	cov_hardfail: cover property (@(posedge I_CLK) ev && I_EV_KIND == EV_HARDFAIL && I_EV_DEFERRED);
	cov_poison: cover property (@(posedge I_CLK) ev && I_EV_KIND == EV_PF_TAG_ERR ##[1:20] O_MCHK);
	cov_bank2_off: cover property (@(posedge I_CLK) ev && I_EV_KIND == EV_BANK2_ERR && ctl2_q == 8'h00);
	cov_split_one_bad: cover property (@(posedge I_CLK) ev && I_EV_KIND == EV_FETCH_SPLIT && (I_HALF0_BAD ^ I_HALF1_BAD));
endmodule : mcel_top

// >>> bench/tb_top.sv
// Self-checking bench for the error logging block
`timescale 1ns/1ps
module tb_top;
	import mcel_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, ev_addr = 32'h0;
	logic pready, pslverr, err, ev_v = 1'b0, ev_def = 1'b0, h0 = 1'b0, h1 = 1'b0, alloc = 1'b0, mchk, stall;
	mcel_event_t ev_kind = EV_NONE;
	logic [QIDW-1:0] ev_qid = 2'h0, alloc_id = 2'h0;
	logic [QDEPTH-1:0] q_busy;
	int failures = 0, n_tests = 0;
	// Core clock, 4 ns period
	always #2 clk = ~clk;
	mcel_top mcel_top_inst (.I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_EV_VALID(ev_v), .I_EV_KIND(ev_kind), .I_EV_ADDR(ev_addr), .I_EV_QID(ev_qid),
		.I_EV_DEFERRED(ev_def), .I_HALF0_BAD(h0), .I_HALF1_BAD(h1), .I_Q_ALLOC(alloc),
		.I_Q_ALLOC_ID(alloc_id), .O_MCHK(mchk), .O_FETCH_STALL(stall), .O_Q_BUSY(q_busy));
	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; pen <= 1'b0;
	endtask : apb
	// One error event pulse; exception sampled after the taking edge
	task automatic ev(input mcel_event_t k, input logic [31:0] a, input logic [QIDW-1:0] q, input logic [1:0] h,
		input logic d);
		@(posedge clk);
		ev_v <= 1'b1; ev_kind <= k; ev_addr <= a; ev_qid <= q; ev_def <= d; {h1, h0} <= h;
		@(posedge clk);
		ev_v <= 1'b0; ev_kind <= EV_NONE;
		#1;
	endtask : ev
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, ADDR_BANK2_CTL, 32'h0); check("bank2_ctl_reset", rd, 32'h0000_00FF);
		apb(1'b0, 8'h18, 32'h0); check("unmapped_err", {31'h0, err}, 32'h1);
		check("unmapped_data", rd, 32'h0);
		// Prefetch poison: flags set, no exception
		ev(EV_PF_TAG_ERR, 32'h0000_1A40, 2'h0, 2'b00, 1'b0); check("pf_mchk", {31'h0, mchk}, 32'h0);
		apb(1'b0, ADDR_BANK0_STATUS, 32'h0); check("pf_flags", rd & 32'h47, 32'h47);
		// Multitag elsewhere logs without exception; on the poisoned line it raises one
		ev(EV_OWN_MULTITAG, 32'h0000_2B80, 2'h0, 2'b00, 1'b0); check("mt_mchk", {31'h0, mchk}, 32'h0);
		apb(1'b0, ADDR_BANK0_STATUS, 32'h0); check("mt_flag", rd & 32'h20, 32'h20);
		ev(EV_OWN_MULTITAG, 32'h0000_1A40, 2'h0, 2'b00, 1'b0); check("hit_mchk", {31'h0, mchk}, 32'h1);
		repeat (30) @(posedge clk);
		apb(1'b0, ADDR_BANK0_STATUS, 32'h0); check("hold", rd & 32'h67, 32'h67);
		apb(1'b1, ADDR_BANK0_STATUS, 32'h0);
		apb(1'b0, ADDR_BANK0_STATUS, 32'h0); check("clear", rd, 32'h0);
		// Demand error always raises the exception
		ev(EV_DEMAND_ERR, 32'h0000_2000, 2'h0, 2'b00, 1'b0); check("dem_mchk", {31'h0, mchk}, 32'h1);
		// Bank 2 with all enables off, then on
		apb(1'b1, ADDR_BANK2_CTL, 32'h0);
		apb(1'b0, ADDR_BANK2_CTL, 32'h0); check("bank2_ctl", rd, 32'h0);
		ev(EV_BANK2_ERR, 32'h0000_0300, 2'h0, 2'b00, 1'b0); check("b2_off_mchk", {31'h0, mchk}, 32'h0);
		apb(1'b0, ADDR_BANK2_STATUS, 32'h0); check("b2_flag", rd & 32'h2, 32'h2);
		apb(1'b1, ADDR_BANK2_CTL, 32'h0000_00FF);
		ev(EV_BANK2_ERR, 32'h0000_0304, 2'h0, 2'b00, 1'b0); check("b2_on_mchk", {31'h0, mchk}, 32'h1);
		// L1 parity: first address kept, later one ignored
		ev(EV_L1_PARITY, 32'hC0DE_0040, 2'h0, 2'b00, 1'b0);
		ev(EV_L1_PARITY, 32'h0BAD_0080, 2'h0, 2'b00, 1'b0);
		apb(1'b0, ADDR_BANK1_ADDR, 32'h0); check("l1_addr", rd, 32'hC0DE_0040);
		apb(1'b0, ADDR_BANK1_STATUS, 32'h0); check("l1_status", rd & 32'h83, 32'h83);
		// Split fetch, each half uncorrectable in turn, then both clean
		apb(1'b1, ADDR_BANK0_STATUS, 32'h0);
		ev(EV_FETCH_SPLIT, 32'h0000_4000, 2'h0, 2'b01, 1'b0); check("split0_mchk", {31'h0, mchk}, 32'h1);
		check("split0_stall", {31'h0, stall}, 32'h0);
		ev(EV_FETCH_SPLIT, 32'h0000_4040, 2'h0, 2'b10, 1'b0); check("split1_stall", {31'h0, stall}, 32'h0);
		check("split1_mchk", {31'h0, mchk}, 32'h1);
		ev(EV_FETCH_SPLIT, 32'h0000_4080, 2'h0, 2'b00, 1'b0); check("split_ok_mchk", {31'h0, mchk}, 32'h0);
		apb(1'b0, ADDR_BANK0_STATUS, 32'h0); check("split_flags", rd & 32'h0A, 32'h0A);
		// Two entries busy; only the deferred hard failure frees its entry
		@(posedge clk);
		alloc <= 1'b1; alloc_id <= 2'h2;
		@(posedge clk);
		alloc_id <= 2'h1;
		@(posedge clk);
		alloc <= 1'b0;
		@(posedge clk);
		check("q_alloc", {28'h0, q_busy}, 32'h6);
		ev(EV_HARDFAIL, 32'h0000_5040, 2'h1, 2'b00, 1'b0);
		@(posedge clk);
		check("q_keep", {28'h0, q_busy}, 32'h6);
		ev(EV_HARDFAIL, 32'h0000_5000, 2'h2, 2'b00, 1'b1);
		@(posedge clk);
		check("q_free", {28'h0, q_busy}, 32'h2);
		apb(1'b0, ADDR_QUEUE, 32'h0); check("q_reg", rd & 32'hF, 32'h2);
		apb(1'b0, ADDR_BANK0_STATUS, 32'h0); check("hf_flag", rd & 32'h10, 32'h10);
		conclude();
	end
endmodule : tb_top
